// [rtl/adcr_pkg.sv]
// Package with the register map, field layout and carrier types.
package adcr_pkg;

  // Result and register widths.
  localparam int unsigned ADCR_RES_W = 10;
  localparam int unsigned ADCR_REG_W = 8;
  localparam int unsigned ADCR_NUM_CH = 2;
  localparam int unsigned ADCR_STS_W = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [13:0] ADCR_IDX_CH6_LOW = 14'h12AC;
  localparam logic [13:0] ADCR_IDX_CH6_HIGH = 14'h12AD;
  localparam logic [13:0] ADCR_IDX_CH7_LOW = 14'h12AE;
  localparam logic [13:0] ADCR_IDX_CH7_HIGH = 14'h12AF;
  localparam logic [13:0] ADCR_IDX_STATUS = 14'h12B0;
  localparam logic [13:0] ADCR_IDX_MASK = 14'h12B1;

  // First converter channel held here.
  localparam logic [2:0] ADCR_FIRST_CHAN = 3'h6;

  // Low register field positions and constant fill.
  localparam int unsigned ADCR_LOW_DATA_LSB = 6;
  localparam int unsigned ADCR_LOW_FLAG_BIT = 0;
  localparam logic [4:0] ADCR_LOW_FILL = 5'h1F;

  // Status register layout: end bits, then overrun bits.
  localparam int unsigned ADCR_STS_DONE_LSB = 0;
  localparam int unsigned ADCR_STS_OVR_LSB = 2;

  // Reset values.
  localparam logic ADCR_FLAG_RST = 1'b0;
  localparam logic [3:0] ADCR_STS_RST = 4'h0;
  localparam logic [3:0] ADCR_MASK_RST = 4'h0;
  localparam logic [31:0] ADCR_RDATA_RST = 32'h0000_0000;

  // Result handed over by the conversion sequencer.
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [ADCR_RES_W-1:0] value;
  } adcr_result_t;

endpackage : adcr_pkg

// [rtl/adcr_chan.sv]
// One channel's result store and result-stored flag.
`timescale 1ns/1ns
module adcr_chan
  import adcr_pkg::*;
(
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // New result and clearing read
  input wire logic wr_en,
  input wire logic [ADCR_RES_W-1:0] wr_value,
  input wire logic rd_clr,
  // Stored state and combinational overrun
  output logic [ADCR_RES_W-1:0] result_q,
  output logic stored_flag_q,
  output logic overrun
);

  // The result has no reset value; only the flag is cleared.
  always_ff @(posedge pclk) begin
    if (clk_en && wr_en) begin
      result_q <= wr_value;
    end
  end

  // A new result wins over a clearing read in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_flag_q <= ADCR_FLAG_RST; // R6
    end else if (clk_en) begin
      if (wr_en) begin
        stored_flag_q <= 1'b1; // R4 R9
      end else if (rd_clr) begin
        stored_flag_q <= 1'b0; // R5
      end
    end
  end

  // A result that lands on an unread one is reported as overrun.
  assign overrun = wr_en && stored_flag_q;

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_en) |=> stored_flag_q && result_q == $past(wr_value);
  endproperty
  a_flag_set: assert property (p_flag_set) // R4
    else $error("flag or result not stored after a result write");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rd_clr && !wr_en) |=> !stored_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // R5
    else $error("flag not cleared by a read");

  property p_flag_reset;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> !stored_flag_q;
  endproperty
  a_flag_reset: assert property (p_flag_reset) // R6
    else $error("flag not zero after reset");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_en && rd_clr) |=> stored_flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) // R9
    else $error("clearing read beat a new result");

endmodule : adcr_chan

// [rtl/adcr_top.sv]
// Conversion result registers for channels 6 and 7 behind an APB slave.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
// How it works
// R1: Each low register shows result bits 1 and 0 in its bits 7 and 6.
// R2: Each high register shows result bits 9 to 2 in its bits 7 to 0.
// R3: Bits 5 to 1 of every low register always read as one.
// R4: Bit 0 of a low register sets whenever a new result is stored.
// R5: Reading either register of a channel clears that channel's flag.
// R6: After reset every flag is zero and the stored results are undefined.
// R7: Writes to the result registers change neither result nor flag.
// R8: A finished conversion sets the end status bit, and the interrupt only if its mask bit is set.
// R9: Only a completed read clears a flag, and a new result wins a tie.
module adcr_top
  import adcr_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Results from the conversion sequencer
  input wire adcr_result_t res_in,
  // Status and interrupt
  output logic conversion_end_flag,
  output logic conversion_end_irq
);

  // Address decode.
  logic [13:0] idx;
  logic word_ok;
  logic hit_res;
  logic hit_sts;
  logic hit_mask;
  logic hit;
  logic sel_ch;
  logic sel_high;

  assign idx = paddr[15:2];
  assign word_ok = (paddr[1:0] == 2'b00);
  assign hit_res = word_ok && (idx >= ADCR_IDX_CH6_LOW)
                   && (idx <= ADCR_IDX_CH7_HIGH);
  assign hit_sts = word_ok && (idx == ADCR_IDX_STATUS);
  assign hit_mask = word_ok && (idx == ADCR_IDX_MASK);
  assign hit = hit_res || hit_sts || hit_mask;
  // Pairs sit on consecutive indices: bit 1 picks the channel, bit 0 high.
  assign sel_ch = idx[1];
  assign sel_high = idx[0];

  // Bus phases. A read is answered once its data is loaded: at once after
  // an enabled setup cycle, one cycle later if the setup fell in a freeze.
  logic setup;
  logic done;
  logic rd_done;
  logic wr_done;
  logic ld_rd;
  logic capt_q;

  assign setup = psel && !penable && clk_en;
  assign ld_rd = psel && !pwrite && clk_en && (!penable || !capt_q);
  assign done = psel && penable && pready;
  assign rd_done = done && !pwrite;
  assign wr_done = done && pwrite;
  assign pready = clk_en && (pwrite || capt_q);
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_q <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        capt_q <= 1'b0;
      end else if (ld_rd) begin
        capt_q <= 1'b1;
      end
    end
  end

  // Channel stores.
  logic [ADCR_NUM_CH-1:0] ch_wr;
  logic [ADCR_NUM_CH-1:0] ch_clr;
  logic [ADCR_NUM_CH-1:0] ch_flag;
  logic [ADCR_NUM_CH-1:0] ch_ovr;
  logic [ADCR_NUM_CH-1:0][ADCR_RES_W-1:0] ch_val;

  for (genvar i = 0; i < ADCR_NUM_CH; i++) begin : g_ch
    assign ch_wr[i] = res_in.valid
                      && (res_in.chan == ADCR_FIRST_CHAN + 3'(i));
    // Either register of the pair clears, on a completed read only.
    assign ch_clr[i] = rd_done && hit_res && (sel_ch == 1'(i)); // R5 R9

    adcr_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .wr_en(ch_wr[i]),
      .wr_value(res_in.value),
      .rd_clr(ch_clr[i]),
      .result_q(ch_val[i]),
      .stored_flag_q(ch_flag[i]),
      .overrun(ch_ovr[i])
    );
  end

  // What a read shows: a result arriving at the capture edge is shown.
  logic [ADCR_RES_W-1:0] view_val;
  logic view_flag;

  always_comb begin
    if (ch_wr[sel_ch]) begin
      view_val = res_in.value;
    end else begin
      view_val = ch_val[sel_ch];
    end
    view_flag = ch_wr[sel_ch] || ch_flag[sel_ch];
  end

  // Sticky status, cleared by a read; new events win over the clear.
  logic [ADCR_STS_W-1:0] sts_q;
  logic [ADCR_STS_W-1:0] sts_evt;
  logic [ADCR_STS_W-1:0] mask_q;
  logic sts_clr;

  assign sts_evt = {ch_ovr, ch_wr};
  assign sts_clr = rd_done && hit_sts;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= ADCR_STS_RST;
    end else if (clk_en) begin
      if (sts_clr) begin
        sts_q <= sts_evt; // R8
      end else begin
        sts_q <= sts_q | sts_evt; // R8
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= ADCR_MASK_RST;
    end else if (wr_done && hit_mask) begin // R7
      mask_q <= pwdata[ADCR_STS_W-1:0];
    end
  end

  assign conversion_end_flag = |sts_q[ADCR_STS_DONE_LSB +: ADCR_NUM_CH];
  assign conversion_end_irq = |(sts_q & mask_q); // R8

  // Read data is captured in an enabled setup cycle, else in the first enabled access cycle, and held for the access.
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  always_comb begin
    prdata_d = ADCR_RDATA_RST;
    if (hit_res && sel_high) begin
      prdata_d[ADCR_REG_W-1:0] = view_val[ADCR_RES_W-1:2]; // R2
    end else if (hit_res) begin
      prdata_d[ADCR_LOW_DATA_LSB +: 2] = view_val[1:0]; // R1
      prdata_d[5:1] = ADCR_LOW_FILL; // R3
      prdata_d[ADCR_LOW_FLAG_BIT] = view_flag; // R4
    end else if (hit_sts) begin
      prdata_d[ADCR_STS_W-1:0] = sts_q | sts_evt;
    end else if (hit_mask) begin
      prdata_d[ADCR_STS_W-1:0] = mask_q;
    end
  end

  // Writes to result registers fall through to nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= ADCR_RDATA_RST;
    end else if (ld_rd) begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  // Helper for the checks below.
  logic [ADCR_RES_W-1:0] cur_val;
  assign cur_val = ch_val[sel_ch];

  // Marks channels that hold a result; undefined results are not checked.
  logic [ADCR_NUM_CH-1:0] written_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      written_q <= {ADCR_NUM_CH{1'b0}};
    end else if (clk_en) begin
      written_q <= written_q | ch_wr;
    end
  end

  property p_high_byte;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_res && sel_high && !(|ch_wr)
       && written_q[sel_ch])
      |=> prdata_q[7:0] == $past(cur_val[9:2]) && prdata_q[31:8] == 24'h0;
  endproperty
  a_high_byte: assert property (p_high_byte) // R2
    else $error("high register does not show result bits 9 to 2");

  property p_low_bits;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_res && !sel_high && !(|ch_wr)
       && written_q[sel_ch])
      |=> prdata_q[7:6] == $past(cur_val[1:0])
          && prdata_q[0] == $past(ch_flag[sel_ch]);
  endproperty
  a_low_bits: assert property (p_low_bits) // R1
    else $error("low register does not show result bits 1 and 0");

  property p_low_fill;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_res && !sel_high) |=> prdata_q[5:1] == 5'h1F;
  endproperty
  a_low_fill: assert property (p_low_fill) // R3
    else $error("low register bits 5 to 1 not all one");

  property p_read_only;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_res && !res_in.valid)
      |=> $stable(ch_val) && $stable(ch_flag);
  endproperty
  a_read_only: assert property (p_read_only) // R7
    else $error("write changed a result register");

  property p_end_status;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ch_wr[0] && mask_q[0] && !(wr_done && hit_mask))
      |=> sts_q[0] && conversion_end_flag && conversion_end_irq;
  endproperty
  a_end_status: assert property (p_end_status) // R8
    else $error("finished conversion did not raise status and interrupt");

  property p_clear_cause;
    @(posedge pclk) disable iff (!presetn)
      $fell(ch_flag[1]) |-> $past(rd_done && hit_res && sel_ch);
  endproperty
  a_clear_cause: assert property (p_clear_cause) // R9
    else $error("flag cleared without a completed read");

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_res && !sel_high && !sel_ch)
      ##1 (done && !ch_wr[0]) |=> !ch_flag[0];
  endproperty
  a_read_clears: assert property (p_read_clears) // R5
    else $error("read of a low register did not clear its flag");

  property p_sts_clear;
    @(posedge pclk) disable iff (!presetn)
      (sts_clr && !(|sts_evt))
      |=> sts_q == ADCR_STS_RST && !conversion_end_flag
          && !conversion_end_irq;
  endproperty
  a_sts_clear: assert property (p_sts_clear)
    else $error("status read did not clear the sticky bits");

  property p_zero_wait;
    @(posedge pclk) disable iff (!presetn)
      (setup && hit) |=> (pready || !clk_en) && !pslverr;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("mapped access answered late or with an error");

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(sts_q) && $stable(mask_q) && $stable(ch_flag)
          && $stable(prdata_q) && $stable(capt_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state changed while the clock enable was low");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_mask) |=> mask_q == $past(pwdata[ADCR_STS_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask register did not take the written value");

  property p_overrun;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ch_wr[0] && ch_flag[0])
      |=> sts_q[ADCR_STS_OVR_LSB] && ch_flag[0];
  endproperty
  a_overrun: assert property (p_overrun) // R4
    else $error("result on an unread one did not set the overrun bit");

  property p_unmapped_rd;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !hit) |=> prdata_q == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read did not return zero");

  property p_high_clears;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_res && sel_high && sel_ch)
      ##1 (done && !ch_wr[1]) |=> !ch_flag[1];
  endproperty
  a_high_clears: assert property (p_high_clears) // R5
    else $error("read of a high register did not clear its flag");

  property p_clear_cause_lo;
    @(posedge pclk) disable iff (!presetn)
      $fell(ch_flag[0]) |-> $past(rd_done && hit_res && !sel_ch);
  endproperty
  a_clear_cause_lo: assert property (p_clear_cause_lo) // R9
    else $error("flag cleared without a completed read");

endmodule : adcr_top

// [verif/adcr_tb_top.sv]
// Self-checking testbench for the channel 6 and 7 result registers.
`timescale 1ns/1ns
module adcr_tb_top
  import adcr_pkg::*;
;
  localparam logic [15:0] A6L = {ADCR_IDX_CH6_LOW, 2'b00};
  localparam logic [15:0] A6H = {ADCR_IDX_CH6_HIGH, 2'b00};
  localparam logic [15:0] A7L = {ADCR_IDX_CH7_LOW, 2'b00};
  localparam logic [15:0] A7H = {ADCR_IDX_CH7_HIGH, 2'b00};
  localparam logic [15:0] ASTS = {ADCR_IDX_STATUS, 2'b00};
  localparam logic [15:0] AMSK = {ADCR_IDX_MASK, 2'b00};
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  adcr_result_t res_in = '0;
  logic conversion_end_flag;
  logic conversion_end_irq;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] rdv;
  logic errv;

  always #10 pclk = ~pclk;

  adcr_top u_adcr_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .res_in(res_in),
    .conversion_end_flag(conversion_end_flag),
    .conversion_end_irq(conversion_end_irq)
  );

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bounded count.
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                    input logic [31:0] m);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h00000000, d, e);
    chk(d & m, exp);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask : wr

  // A result pulse lasts one cycle and is taken at the following edge.
  task automatic push(input logic [2:0] ch, input logic [9:0] v);
    @(posedge pclk);
    res_in <= '{valid: 1'b1, chan: ch, value: v};
    @(posedge pclk);
    res_in.valid <= 1'b0;
    #1;
  endtask : push

  task automatic outs(input logic irq, input logic endf);
    @(negedge pclk);
    chk({30'h0, conversion_end_irq, conversion_end_flag}, {30'h0, irq, endf});
  endtask : outs

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A6L, 32'h3E, 32'hFFFFFF3F);
    rd(A7L, 32'h3E, 32'hFFFFFF3F);
    rd(ASTS, 32'h0, ALL);
    rd(AMSK, 32'h0, ALL);
    apb(1'b0, 16'h0100, 32'h0, rdv, errv);
    chk({rdv[30:0], errv}, 32'h1);
    $display("test reset done");
    wr(AMSK, 32'h1);
    push(3'h6, 10'h2D5);
    outs(1'b1, 1'b1);
    rd(A6L, 32'h7F, ALL);
    rd(A6L, 32'h7E, ALL);
    push(3'h6, 10'h2D5);
    push(3'h6, 10'h2D5);
    rd(A6H, 32'hB5, ALL);
    rd(A6L, 32'h3E, 32'hFFFFFF3F);
    rd(ASTS, 32'h5, ALL);
    outs(1'b0, 1'b0);
    $display("test ch6 layout and flag done");
    push(3'h7, 10'h0C3);
    outs(1'b0, 1'b1);
    wr(A7L, 32'h0);
    wr(A7H, ALL);
    rd(A7L, 32'hFF, ALL);
    rd(A7H, 32'h30, ALL);
    rd(ASTS, 32'h2, ALL);
    $display("test read-only done");
    fork
      apb(1'b0, A6H, 32'h0, rdv, errv);
      begin
        @(posedge pclk);
        push(3'h6, 10'h3FF);
      end
    join
    chk(rdv, 32'hB5);
    rd(A6L, 32'hFF, ALL);
    push(3'h5, 10'h000);
    rd(A6H, 32'hFF, ALL);
    rd(ASTS, 32'h1, ALL);
    $display("test coincident set done");
    clk_en <= 1'b0;
    push(3'h6, 10'h001);
    @(posedge pclk);
    clk_en <= 1'b1;
    outs(1'b0, 1'b0);
    rd(A6L, 32'hFE, ALL);
    fork
      apb(1'b0, A6H, 32'h0, rdv, errv);
      begin
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (2) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    chk(rdv, 32'hFF);
    $display("test clock enable done");
    push(3'h7, 10'h3C0);
    outs(1'b0, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    outs(1'b0, 1'b0);
    rd(A7L, 32'h3E, 32'hFFFFFF3F);
    rd(AMSK, 32'h0, ALL);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : adcr_tb_top
